// ==== src/smooth_backup.v ====
// Smooth register backup sequencer with AXI4-Lite control registers
//
// Notes on behaviour
// - Never store a register still being computed
// - Writes set dirty; clean registers skipped
// - Trigger loads pending from dirty, clears dirty
// - Incoming access to pending register raises priority
// - Sequence atomic; later triggers wait; fault stops
// - Priority first, then lowest pending from one
// - Switch does store then load per register
// - Find-first over 63 picks one, clears flags
// - Application wins load/store unit without priority
// - Priority stalls decode, frees load/store unit
// - Incoming thread starts at trigger instantly
// - Switch completion copies incoming to outgoing pointer
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "smooth_backup_defs.vh"

module smooth_backup (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core events and scoreboard
  input wire backupTrigger,
  input wire regWrite,
  input wire [5:0] regWriteIdx,
  input wire [63:0] inFlight,
  // Decode stage
  input wire [63:0] decodeUse,
  output reg decodeStall,
  // Load/store unit
  input wire lsuIdle,
  output reg memValid,
  output reg memWrite,
  output reg [31:0] memAddr,
  output reg [5:0] memRegIdx,
  input wire memReady,
  input wire memFault,
  // Status
  output reg seqBusy
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SELECT = 2'h1;
  localparam ST_STORE = 2'h2;
  localparam ST_LOAD = 2'h3;

  // ------------------------------------------------------------
  // Find-first helper
  // ------------------------------------------------------------
  function [5:0] findFirst;
    input [63:0] vec;
    integer i;
    begin
      findFirst = 6'h00;
      for (i = `NUM_REGS - 1; i >= 1; i = i - 1) begin
        if (vec[i]) begin
          findFirst = i[5:0];
        end
      end
    end
  endfunction

  function [31:0] slotAddr;
    input [31:0] base;
    input [5:0] idx;
    begin
      slotAddr = base + {26'h0000000, idx} * `REG_BYTES;
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [1:0] state_reg;
  reg [63:0] dirty_reg;
  reg [63:0] pending_reg;
  reg [63:0] prio_reg;
  reg [5:0] curIdx_reg;
  reg switchMode_reg;
  reg activeSwitch_reg;
  reg fault_reg;
  reg defer_reg;
  reg swTrigger_reg;
  reg [31:0] outPtr_reg;
  reg [31:0] inPtr_reg;
  reg [7:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;

  wire [63:0] writeBit = regWrite ? (64'h1 << regWriteIdx) : 64'h0;
  wire trigAny = backupTrigger | swTrigger_reg | defer_reg;
  wire [63:0] usable = pending_reg & ~inFlight;
  wire [63:0] prioUsable = prio_reg & pending_reg & ~inFlight;
  wire prioAny = |(prio_reg & pending_reg);
  // Selection: priority requests first, then plain pending
  wire [5:0] pick = (|prioUsable) ? findFirst(prioUsable) : findFirst(usable);
  wire canIssue = (|usable) && (prioAny || lsuIdle);
  wire memDone = memValid && memReady;
  wire doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire faultClear = doWrite && awAddr_reg == `OFS_STATUS &&
                    wStrb_reg[0] && wData_reg[`STAT_FAULT_BIT];
  wire startSeq = (state_reg == ST_IDLE) && trigAny;

  // ------------------------------------------------------------
  // Flags and sequencer
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      dirty_reg <= 64'h0;
      pending_reg <= 64'h0;
      prio_reg <= 64'h0;
      curIdx_reg <= 6'h00;
      activeSwitch_reg <= 1'h0;
      fault_reg <= 1'h0;
      defer_reg <= 1'h0;
      memValid <= 1'h0;
      memWrite <= 1'h0;
      memAddr <= 32'h00000000;
      memRegIdx <= 6'h00;
      decodeStall <= 1'h0;
      seqBusy <= 1'h0;
      outPtr_reg <= `PTR_RESET;
    end else begin
      // Decode held while it uses a register not yet saved
      // Stall decode stage
      decodeStall <= |(decodeUse & pending_reg & 64'hFFFFFFFFFFFFFFFE);
      prio_reg <= (prio_reg | decodeUse) & pending_reg &
                  64'hFFFFFFFFFFFFFFFE;
      seqBusy <= (state_reg != ST_IDLE) || trigAny;
      if (faultClear) begin
        fault_reg <= 1'h0;
      end
      if (state_reg != ST_IDLE && (backupTrigger || swTrigger_reg)) begin
        defer_reg <= 1'h1;
      end
      dirty_reg <= (dirty_reg | writeBit) & 64'hFFFFFFFFFFFFFFFE;
      case (state_reg)
        ST_IDLE: begin
          if (trigAny) begin
            pending_reg <= dirty_reg & 64'hFFFFFFFFFFFFFFFE;
            dirty_reg <= writeBit & 64'hFFFFFFFFFFFFFFFE;
            prio_reg <= 64'h0;
            activeSwitch_reg <= switchMode_reg;
            defer_reg <= 1'h0;
            state_reg <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          if (pending_reg == 64'h0) begin
            if (activeSwitch_reg) begin
              outPtr_reg <= inPtr_reg;
            end
            state_reg <= ST_IDLE;
          end else if (canIssue) begin
            curIdx_reg <= pick;
            memRegIdx <= pick;
            memValid <= 1'h1;
            memWrite <= 1'h1;
            memAddr <= slotAddr(outPtr_reg, pick);
            state_reg <= ST_STORE;
          end
        end
        ST_STORE: begin
          if (memDone) begin
            if (memFault) begin
              memValid <= 1'h0;
              fault_reg <= 1'h1;
              pending_reg <= 64'h0;
              prio_reg <= 64'h0;
              state_reg <= ST_IDLE;
            end else if (activeSwitch_reg) begin
              memWrite <= 1'h0;
              memAddr <= slotAddr(inPtr_reg, curIdx_reg);
              state_reg <= ST_LOAD;
            end else begin
              memValid <= 1'h0;
              pending_reg[curIdx_reg] <= 1'h0;
              prio_reg[curIdx_reg] <= 1'h0;
              state_reg <= ST_SELECT;
            end
          end
        end
        ST_LOAD: begin
          if (memDone) begin
            memValid <= 1'h0;
            if (memFault) begin
              fault_reg <= 1'h1;
              pending_reg <= 64'h0;
              prio_reg <= 64'h0;
              state_reg <= ST_IDLE;
            end else begin
              pending_reg[curIdx_reg] <= 1'h0;
              prio_reg[curIdx_reg] <= 1'h0;
              state_reg <= ST_SELECT;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (memDone && memFault) begin
        fault_reg <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'h0;
      s_axi_wready <= 1'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `RESP_OKAY;
      awHeld_reg <= 1'h0;
      wHeld_reg <= 1'h0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      switchMode_reg <= `CTRL_RESET;
      swTrigger_reg <= 1'h0;
      inPtr_reg <= `PTR_RESET;
    end else begin
      swTrigger_reg <= 1'h0;
      s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'h1;
        awAddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'h1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'h0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
      if (doWrite) begin
        awHeld_reg <= 1'h0;
        wHeld_reg <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= `RESP_OKAY;
        case ({awAddr_reg[7:2], 2'h0})
          `OFS_CONTROL: begin
            if (wStrb_reg[0]) begin
              switchMode_reg <= wData_reg[`CTRL_SWITCH_BIT];
              swTrigger_reg <= wData_reg[`CTRL_TRIGGER_BIT];
            end
          end
          `OFS_STATUS: begin
          end
          `OFS_IN_PTR: begin
            if (wStrb_reg[0]) inPtr_reg[7:0] <= wData_reg[7:0];
            if (wStrb_reg[1]) inPtr_reg[15:8] <= wData_reg[15:8];
            if (wStrb_reg[2]) inPtr_reg[23:16] <= wData_reg[23:16];
            if (wStrb_reg[3]) inPtr_reg[31:24] <= wData_reg[31:24];
          end
          `OFS_OUT_PTR, `OFS_PENDING_LO, `OFS_PENDING_HI,
          `OFS_DIRTY_LO, `OFS_DIRTY_HI: begin
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'h0;
        s_axi_rvalid <= 1'h1;
        s_axi_rresp <= `RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          `OFS_CONTROL: s_axi_rdata <= {31'h0, switchMode_reg};
          `OFS_STATUS: s_axi_rdata <= {29'h0, defer_reg, fault_reg,
                                       state_reg != ST_IDLE};
          `OFS_OUT_PTR: s_axi_rdata <= outPtr_reg;
          `OFS_IN_PTR: s_axi_rdata <= inPtr_reg;
          `OFS_PENDING_LO: s_axi_rdata <= pending_reg[31:0];
          `OFS_PENDING_HI: s_axi_rdata <= pending_reg[63:32];
          `OFS_DIRTY_LO: s_axi_rdata <= dirty_reg[31:0];
          `OFS_DIRTY_HI: s_axi_rdata <= dirty_reg[63:32];
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule // smooth_backup

// ==== src/smooth_backup_defs.vh ====
// Constants for the smooth backup sequencer
`ifndef SMOOTH_BACKUP_DEFS_VH
`define SMOOTH_BACKUP_DEFS_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_OUT_PTR 8'h08
`define OFS_IN_PTR 8'h0C
`define OFS_PENDING_LO 8'h10
`define OFS_PENDING_HI 8'h14
`define OFS_DIRTY_LO 8'h18
`define OFS_DIRTY_HI 8'h1C
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_SWITCH_BIT 0
`define CTRL_TRIGGER_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_FAULT_BIT 1
`define STAT_DEFER_BIT 2
// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define CTRL_RESET 1'h1
`define PTR_RESET 32'h00000000
`define REG_BYTES 32'h00000008
`define NUM_REGS 64
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== testbench/smooth_backup_asserts.sv ====
// Port checks for the smooth backup sequencer
`timescale 1ns/1ps
module smooth_backup_asserts (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Core side
  input wire backupTrigger,
  input wire [63:0] inFlight,
  input wire [63:0] decodeUse,
  input wire decodeStall,
  input wire lsuIdle,
  input wire seqBusy,
  // Memory side
  input wire memValid,
  input wire memWrite,
  input wire [31:0] memAddr,
  input wire [5:0] memRegIdx,
  input wire memReady,
  input wire memFault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  busy_save_a: assert property (
    $rose(memValid) |-> !(($past(inFlight) >> memRegIdx) & 64'h1))
    else $error("busy register stored");
  stall_cause_a: assert property (
    decodeStall |-> |$past(decodeUse)) else $error("stall without use");
  lsu_yield_a: assert property (
    $rose(memValid) |-> $past(lsuIdle) || |$past(decodeUse))
    else $error("slot taken from application");
  store_load_a: assert property (
    memValid && memReady && memWrite && !memFault |=>
      memValid && !memWrite && $stable(memRegIdx))
    else $error("store not followed by load");
  req_hold_a: assert property (
    memValid && !memReady |=>
      memValid && $stable(memAddr) && $stable(memWrite))
    else $error("request changed early");
  fault_stop_a: assert property (
    memValid && memReady && memFault |=> !memValid [*2])
    else $error("access after fault");
  busy_req_a: assert property (
    memValid |-> seqBusy) else $error("access while idle");
  trig_busy_a: assert property (
    backupTrigger |-> ##[1:2] seqBusy) else $error("trigger lost");
endmodule // smooth_backup_asserts

bind smooth_backup smooth_backup_asserts chk_i (.*);

// ==== testbench/lsu_model.sv ====
// Load/store unit model answering sequencer requests
`timescale 1ns/1ps
module lsu_model (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Behaviour select
  input wire slowMode,
  input wire faultMode,
  // Answer
  output reg memReady,
  output reg memFault
);
  integer seed;
  reg rdy;
  initial seed = 32'hA66A;
  // Random stalls when slow; fault line toggles while not ready
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      memReady <= 1'b0;
      memFault <= 1'b0;
    end else begin
      rdy = !slowMode || ($random(seed) & 1);
      memReady <= rdy;
      memFault <= rdy ? faultMode : !memFault;
    end
  end
endmodule // lsu_model

// ==== testbench/smooth_backup_bench.sv ====
// Self-checking bench for the smooth backup sequencer
`timescale 1ns/1ps
`include "smooth_backup_defs.vh"
module smooth_backup_bench;
  reg ref_clk, nrst, backupTrigger, regWrite, lsuIdle, slowMode, faultMode;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg s_axi_arvalid, s_axi_rready;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, rd, inPtr, outPtr;
  reg [3:0] s_axi_wstrb;
  reg [5:0] regWriteIdx;
  reg [63:0] inFlight, decodeUse, dirty;
  reg [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, decodeStall, memValid, memWrite, memReady;
  wire memFault, seqBusy;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, memAddr;
  wire [5:0] memRegIdx;
  reg [38:0] gotQ[$], expQ[$];
  integer error_cnt, n_compared, seed, i, r;
  smooth_backup uut (.*);
  lsu_model lsu (.*);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (memValid && memReady) gotQ.push_back({memWrite, memRegIdx, memAddr});
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task final_report;
    begin
      $display("errors %0d compares %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task tmo;
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t wait ran out", $time);
      final_report;
    end
  endtask
  task chk(input [38:0] got, input [38:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task axiWr(input [7:0] a, input [31:0] d);
    reg aw, w, b;
    begin
      @(posedge ref_clk);
      {aw, w, b} = 3'b111;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      for (i = 0; i < 99 && b; i = i + 1) begin
        @(posedge ref_clk);
        if (aw && s_axi_awready) aw = 1'b0;
        if (w && s_axi_wready) w = 1'b0;
        if (!aw && !w && s_axi_bvalid) {b, rsp} = {1'b0, s_axi_bresp};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, b};
      end
      if (b) tmo;
    end
  endtask
  task axiRd(input [7:0] a);
    reg ar, rv;
    begin
      @(posedge ref_clk);
      {ar, rv} = 2'b11;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      for (i = 0; i < 99 && rv; i = i + 1) begin
        @(posedge ref_clk);
        if (ar && s_axi_arready) ar = 1'b0;
        else if (!ar && s_axi_rvalid) rv = 1'b0;
        {s_axi_arvalid, s_axi_rready} <= {ar, rv};
      end
      {rsp, rd} = {s_axi_rresp, s_axi_rdata};
      if (rv) tmo;
    end
  endtask
  task regWr(input [5:0] n);
    begin
      {regWrite, regWriteIdx} <= {1'b1, n};
      dirty[n] = 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task trig;
    begin
      backupTrigger <= 1'b1;
      @(posedge ref_clk);
      backupTrigger <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  function [31:0] slot(input [31:0] p, input [5:0] n);
    slot = p + n * `REG_BYTES;
  endfunction
  task addReg(input [5:0] n);
    begin
      expQ.push_back({1'b1, n, slot(outPtr, n)});
      expQ.push_back({1'b0, n, slot(inPtr, n)});
    end
  endtask
  task planSeq(input [5:0] first, input [5:0] last);
    begin
      if (first != 0) addReg(first);
      for (i = 1; i < 64; i = i + 1)
        if (dirty[i] && i != first && i != last) addReg(i[5:0]);
      if (last != 0) addReg(last);
      dirty = 0;
      outPtr = inPtr;
    end
  endtask
  task checkSeq;
    begin
      chk(gotQ.size(), expQ.size());
      for (i = 0; i < expQ.size(); i = i + 1) chk(gotQ[i], expQ[i]);
      gotQ.delete();
      expQ.delete();
    end
  endtask
  task waitCnt(input integer c);
    begin
      for (i = 0; i < 900 && gotQ.size() < c; i = i + 1) @(posedge ref_clk);
      if (i == 900) tmo;
    end
  endtask
  task waitIdle;
    begin
      repeat (2) @(posedge ref_clk);
      for (i = 0; i < 3000 && seqBusy !== 1'b0; i = i + 1) @(posedge ref_clk);
      if (i == 3000) tmo;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hA66A;
    {nrst, backupTrigger, regWrite, lsuIdle, slowMode, faultMode} = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {regWriteIdx, inFlight, decodeUse, dirty} = 198'h0;
    {error_cnt, n_compared, outPtr, inPtr} = 128'h0;
    repeat (4) @(posedge ref_clk);
    {nrst, lsuIdle} <= 2'b11;
    @(posedge ref_clk);
    axiRd(`OFS_CONTROL);
    chk(rd, `CTRL_RESET);
    axiRd(8'h24);
    chk({rsp, rd}, {`RESP_SLVERR, 32'h0});
    for (r = 0; r < 3; r = r + 1) begin
      slowMode <= r[0];
      inPtr = $random(seed) & 32'hFFFFFF00;
      axiWr(`OFS_IN_PTR, inPtr);
      regWr(1);
      regWr(63);
      repeat (4) regWr($random(seed));
      axiRd(`OFS_DIRTY_HI);
      chk(rd, dirty[63:32]);
      if (r == 2) axiWr(`OFS_CONTROL, 32'h00000003);
      else trig;
      waitIdle;
      planSeq(0, 0);
      checkSeq;
      axiRd(`OFS_OUT_PTR);
      chk(rd, outPtr);
      axiRd(`OFS_DIRTY_LO);
      chk(rd, dirty[31:0]);
    end
    slowMode <= 1'b0;
    regWr(5);
    regWr(9);
    regWr(40);
    {lsuIdle, inFlight[5], decodeUse[40]} <= 3'b011;
    trig;
    @(posedge ref_clk);
    chk(decodeStall, 1'b1);
    waitCnt(2);
    decodeUse <= 64'h0;
    repeat (20) @(posedge ref_clk);
    chk(gotQ.size(), 2);
    lsuIdle <= 1'b1;
    waitCnt(4);
    repeat (20) @(posedge ref_clk);
    chk(gotQ.size(), 4);
    inFlight <= 64'h0;
    waitIdle;
    planSeq(40, 5);
    checkSeq;
    slowMode <= 1'b1;
    regWr(3);
    regWr(7);
    trig;
    planSeq(0, 0);
    regWr(12);
    trig;
    waitIdle;
    planSeq(0, 0);
    checkSeq;
    faultMode <= 1'b1;
    regWr(2);
    regWr(4);
    trig;
    waitIdle;
    chk(gotQ.size(), 1);
    axiRd(`OFS_STATUS);
    chk(rd[`STAT_FAULT_BIT], 1'b1);
    axiWr(`OFS_STATUS, 32'h00000002);
    axiRd(`OFS_STATUS);
    chk(rd[`STAT_FAULT_BIT], 1'b0);
    axiWr(8'h24, 32'h00000000);
    chk(rsp, `RESP_SLVERR);
    final_report;
  end
endmodule // smooth_backup_bench
